/* File: core/mlcr_top.sv */
// Lookup index, video DAC value, identity, loop sample timing, fault output
// and bias startup limiter. Assumes a serial slave delivers byte accesses
// and a lookup memory answers the table address in the same cycle.
// Alarm, supply and bias step inputs come from logic on this clock.
`timescale 1ns/1ns
`default_nettype none
`include "mlcr_defines.svh"
module mlcr_top
	import mlcr_pkg::*;
#(
	parameter logic [7:0] PART_ID = 8'h3c, // Arbitrary value
	parameter logic [7:0] PART_REV = 8'h01, // Arbitrary value
	parameter int ALARMS = 8
)
(
	input wire logic mclk,
	input wire logic rstn,
	input wire mlcr_acc_t acc,
	output logic [7:0] rdata,
	input wire logic [15:0] fourth_monitor_input,
	input wire logic conv_done,
	input wire logic video_dac_auto_enable,
	input wire logic double_table_mode,
	input wire logic upper_half_select,
	output logic [7:0] table_addr,
	input wire logic [7:0] table_data,
	output logic [7:0] video_gain_dac_value,
	input wire logic burst_enable_input,
	output logic loop_sample,
	input wire logic [ALARMS-1:0] alarm_state,
	input wire logic [ALARMS-1:0] alarm_fault_enable,
	input wire logic supply_low_alarm_enabled,
	input wire logic supply_above_low,
	input wire logic transmit_disable_input,
	input wire logic fault_present,
	output logic shutdown_gate_output,
	output logic transmit_fault_output,
	output logic [7:0] slave_address,
	input wire logic startup_active,
	input wire logic bias_step_tick,
	input wire logic [12:0] bias_target,
	output logic [12:0] laser_bias_output
);
	// ==========================================
	// Pin synchronisers
	// Both pins come from outside the clock domain, so each passes two
	// flip-flops before any logic reads it; this costs two cycles of
	// latency on the first loop sample, well inside its tolerance.
	logic [1:0] ben_sync_reg; // Burst enable, two stages
	logic [1:0] txd_sync_reg; // Transmit disable, two stages
	logic txd_last_reg; // For edge detect on the stable stage
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			ben_sync_reg <= 2'h0;
			txd_sync_reg <= 2'h0;
			txd_last_reg <= 1'b0;
		end
		else
		begin
			ben_sync_reg <= {ben_sync_reg[0], burst_enable_input};
			txd_sync_reg <= {txd_sync_reg[0], transmit_disable_input};
			txd_last_reg <= txd_sync_reg[1];
		end
	end
	// Only the second stage is read; the first may still be settling
	logic ben_s;
	logic txd_edge;
	assign ben_s = ben_sync_reg[1];
	assign txd_edge = txd_sync_reg[1] ^ txd_last_reg;

	// ==========================================
	// Lookup index and table address
	// The monitor result is divided by a power of two, so a shift does it;
	// the five bits left over land the index between 80h and 9fh.
	logic [7:0] index; // Computed voltage index
	assign index = 8'(fourth_monitor_input >> `MLCR_INDEX_SHIFT)
		+ `MLCR_INDEX_OFFSET;
	// Table address, combinational so the memory answers in this cycle
	always_comb
	begin
		// Single mode uses all 32 bytes
		if (!double_table_mode)
			table_addr = {3'b100, index[4:0]};
		else
			table_addr = {3'b100, upper_half_select, index[4:1]};
	end

	// ==========================================
	// Host writable registers
	// All writes need the level two password from the serial slave side.
	// Unmapped offsets and the identity bytes fall through untouched.
	logic [7:0] dac_reg;
	logic [3:0] rate_reg;
	logic [7:0] cfg_reg;
	logic [7:0] step_reg;
	logic [7:0] devaddr_reg;
	logic wr_ok;
	assign wr_ok = acc.wr && acc.pw2_ok;
	// Conversion loads take priority over a host write in the same cycle
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
			dac_reg <= `MLCR_RESET_BYTE;
		else if (conv_done)
			dac_reg <= table_data;
		else if (wr_ok && !video_dac_auto_enable
			&& acc.addr == `MLCR_OFS_DAC)
			dac_reg <= acc.wdata;
	end
	// Only bits seven, six and four of the config byte are kept; the
	// reserved bits read back as zero.
	// Configuration bytes
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			rate_reg <= 4'h0;
			cfg_reg <= `MLCR_RESET_BYTE;
			step_reg <= `MLCR_RESET_BYTE;
			devaddr_reg <= `MLCR_RESET_BYTE;
		end
		else if (wr_ok)
		begin
			// Identity bytes simply ignore writes
			unique case (acc.addr)
				`MLCR_OFS_RATE: rate_reg <= acc.wdata[3:0];
				`MLCR_OFS_CFG: cfg_reg <= acc.wdata & `MLCR_CFG_MASK;
				`MLCR_OFS_STEP: step_reg <= acc.wdata;
				`MLCR_OFS_DEVADDR: devaddr_reg <= acc.wdata;
				default: ;
			endcase
		end
	end
	assign video_gain_dac_value = dac_reg;

	// ==========================================
	// Read mux; no password reads as zero
	// Purely combinational: the serial slave latches rdata in the same
	// cycle that it presents the address, so no wait state is needed.
	always_comb
	begin
		rdata = 8'h00;
		if (acc.pw2_ok)
		begin
			unique case (acc.addr)
				`MLCR_OFS_DAC: rdata = dac_reg;
				`MLCR_OFS_ID: rdata = PART_ID;
				`MLCR_OFS_VER: rdata = PART_REV;
				`MLCR_OFS_RATE: rdata = {4'h0, rate_reg};
				`MLCR_OFS_CFG: rdata = cfg_reg;
				`MLCR_OFS_STEP: rdata = step_reg;
				`MLCR_OFS_DEVADDR: rdata = devaddr_reg;
				default: rdata = 8'h00;
			endcase
		end
	end

	// ==========================================
	// Slave address select
	// Registered so the address never glitches while a frame is decoded;
	// the cost is one cycle before a new select or address takes effect.
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
			slave_address <= `MLCR_DEFAULT_SLAVE;
		else if (cfg_reg[`MLCR_CFG_SLAVE_ADDRESS_SELECT_BIT])
			slave_address <= devaddr_reg;
		else
			slave_address <= `MLCR_DEFAULT_SLAVE;
	end

	// ==========================================
	// Loop sample timing
	// Rate codes above the top entry fold onto it, so a host may write
	// any nibble without reaching an undefined interval.
	logic [3:0] code;
	assign code = (rate_reg > `MLCR_MAX_CODE) ? `MLCR_MAX_CODE : rate_reg;
	// Table times follow 200 ns steps with jumps; encode per code
	function automatic logic [9:0] first_cycles(input logic [3:0] c);
		int ns;
		ns = 350;
		unique case (c)
			4'h0: ns = 350;
			4'h1: ns = 550;
			4'h2: ns = 750;
			4'h3: ns = 950;
			4'h4: ns = 1350;
			4'h5: ns = 1550;
			4'h6: ns = 1750;
			4'h7: ns = 2150;
			4'h8: ns = 2950;
			default: ns = 3150;
		endcase
		// Least time, rounded up
		first_cycles = 10'((ns + `MLCR_CLK_NS - 1) / `MLCR_CLK_NS);
	endfunction
	// Repeat period, exact in clock cycles at the 10 ns clock
	function automatic logic [9:0] rep_cycles(input logic [3:0] c);
		int ns;
		ns = 800;
		unique case (c)
			4'h0: ns = 800;
			4'h1: ns = 1200;
			4'h2: ns = 1600;
			4'h3: ns = 2000;
			4'h4: ns = 2800;
			4'h5: ns = 3200;
			4'h6: ns = 3600;
			4'h7: ns = 4400;
			4'h8: ns = 6000;
			default: ns = 6400;
		endcase
		rep_cycles = 10'(ns / `MLCR_CLK_NS);
	endfunction
	// Sequencer state and cycle counter; ten bits hold the longest period
	mlcr_st_t st_reg;
	logic [9:0] cnt_reg;
	// Counts from burst enable; dropping burst enable aborts at once
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			st_reg <= MLCR_IDLE;
			cnt_reg <= 10'h000;
			loop_sample <= 1'b0;
		end
		else
		begin
			loop_sample <= 1'b0;
			if (!ben_s)
			begin
				st_reg <= MLCR_IDLE;
				cnt_reg <= 10'h000;
			end
			else
			begin
				unique case (st_reg)
					// Burst just seen; start counting the first delay
					MLCR_IDLE:
					begin
						st_reg <= MLCR_FIRST;
						cnt_reg <= 10'h001;
					end
					// First sample once the least delay has passed
					MLCR_FIRST:
					begin
						if (cnt_reg >= first_cycles(code))
						begin
							loop_sample <= 1'b1;
							st_reg <= MLCR_REPEAT;
							cnt_reg <= 10'h001;
						end
						else
							cnt_reg <= cnt_reg + 10'h001;
					end
					// Then one sample per repeat period until burst ends
					MLCR_REPEAT:
					begin
						if (cnt_reg >= rep_cycles(code))
						begin
							loop_sample <= 1'b1;
							cnt_reg <= 10'h001;
						end
						else
							cnt_reg <= cnt_reg + 10'h001;
					end
				endcase
			end
		end
	end

	// ==========================================
	// Alarm latching and fault outputs
	// The latch remembers any alarm seen while latching is on, so a short
	// alarm between two polls still shows on the fault output.
	logic [ALARMS-1:0] latched_reg;
	logic armed_reg; // Supply has been seen above the low set point
	logic latch_on;
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
			armed_reg <= 1'b0;
		else if (supply_above_low)
			armed_reg <= 1'b1;
	end
	// A supply still ramping would otherwise latch a false low alarm
	// Latching held off during slow power-on
	assign latch_on = cfg_reg[`MLCR_CFG_LATCH_BIT]
		&& (!supply_low_alarm_enabled || armed_reg);
	// New alarms win over a clearing transition
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
			latched_reg <= '0;
		else if (!latch_on)
			latched_reg <= '0;
		else if (txd_edge)
			latched_reg <= alarm_state;
		else
			latched_reg <= latched_reg | alarm_state;
	end
	// Both pin drivers are registered so they never glitch
	// Fault output is the OR of live and latched enabled alarms
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			transmit_fault_output <= 1'b0;
			shutdown_gate_output <= 1'b0;
		end
		else
		begin
			transmit_fault_output <= |((alarm_state | latched_reg)
				& alarm_fault_enable);
			shutdown_gate_output <= cfg_reg[`MLCR_CFG_POL_BIT]
				^ fault_present;
		end
	end

	// ==========================================
	// Bias startup step limiter
	// The step register weights bits 12 down to 5 of the bias word, so
	// it is shifted up by five; zero falls back to a single LSB.
	// Outside startup the output follows the target directly.
	logic [12:0] step;
	assign step = (step_reg == 8'h00) ? 13'h0001
		: {step_reg, 5'h00};
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
			laser_bias_output <= 13'h0000;
		else if (!startup_active)
			laser_bias_output <= bias_target;
		else if (bias_step_tick)
		begin
			if (bias_target > laser_bias_output)
				laser_bias_output <= (bias_target - laser_bias_output > step)
					? laser_bias_output + step : bias_target;
			else if (laser_bias_output - bias_target > step)
				laser_bias_output <= laser_bias_output - step;
			else
				laser_bias_output <= bias_target;
		end
	end
endmodule
`default_nettype wire

/* File: core/mlcr_defines.svh */
// Constants for the monitor lookup and configuration register group.
// Assumes an internal byte-wide register port from the serial bus slave.
// What this block does
// - Index is monitor result over 800h plus 80h
// - Single mode: address 100 plus five index bits
// - Double mode: half select bit four, index 4:1
// - Conversion end loads DAC value from table
// - DAC writes need password, auto enable clear
// - Identity and version bytes read only, password
// - Rate register low four bits, upper zero
// - First sample after delay, then repeat period
// - Codes above 1001b act as 1001b
// - Gate output level follows polarity bit seven
// - Fault output ORs enabled alarm states
// - Latch enable holds alarms until disable toggles
// - Supply low enabled suppresses latch until recovery
// - Address select clear gives A2h, else programmed
// - Startup bias step limited, weights bit12..bit5
// - Step value zero moves one LSB per step
// - Programmed address byte used when select set
`ifndef MLCR_DEFINES_SVH
`define MLCR_DEFINES_SVH
// ==========================================
// Register offsets
`define MLCR_OFS_DAC 8'h85
`define MLCR_OFS_ID 8'h86
`define MLCR_OFS_VER 8'h87
`define MLCR_OFS_RATE 8'h88
`define MLCR_OFS_CFG 8'h89
`define MLCR_OFS_STEP 8'h8a
`define MLCR_OFS_DEVADDR 8'h8c
// ==========================================
// Fields and values
`define MLCR_CFG_POL_BIT 7
`define MLCR_CFG_LATCH_BIT 6
`define MLCR_CFG_SLAVE_ADDRESS_SELECT_BIT 4
`define MLCR_CFG_MASK 8'hd0
`define MLCR_DEFAULT_SLAVE 8'ha2
`define MLCR_INDEX_OFFSET 8'h80
`define MLCR_INDEX_SHIFT 11
`define MLCR_RESET_BYTE 8'h00
`define MLCR_MAX_CODE 4'h9
// ==========================================
// Timing
`define MLCR_CLK_NS 10
`define MLCR_FIRST_BASE_NS 350
`define MLCR_REP_BASE_NS 800
`endif

/* File: core/mlcr_pkg.sv */
// Types for the monitor lookup and configuration register group.
// Assumes the defines header is compiled alongside.
`default_nettype none
package mlcr_pkg;
	// Host register access from the serial slave
	typedef struct packed {
		logic wr;
		logic [7:0] addr;
		logic [7:0] wdata;
		logic pw2_ok;
	} mlcr_acc_t;
	// Loop sampling states
	typedef enum logic [1:0] {MLCR_IDLE, MLCR_FIRST, MLCR_REPEAT} mlcr_st_t;
endpackage
`default_nettype wire

/* File: test/mlcr_host.sv */
// Host model for the register port of the lookup and config group.
// Assumes the bench calls wr and rd; pw holds the password state.
`timescale 1ns/1ns
`default_nettype none
module mlcr_host
	import mlcr_pkg::*;
(
	input wire logic mclk,
	input wire logic [7:0] rdata,
	output var mlcr_acc_t acc
);
	// ==========
	// Bus cycles
	logic pw = 1'b1; // Password granted
	initial acc = '0;
	// One write, taken at the second edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		acc <= '{1'b1, a, d, pw};
		@(posedge mclk);
		// Released lines show the inverse, never the old value
		acc <= '{1'b0, ~a, ~d, pw};
	endtask
	// One read; the answer is combinational
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge mclk);
		acc <= '{1'b0, a, 8'h00, pw};
		@(posedge mclk);
		d = rdata;
	endtask
endmodule
`default_nettype wire

/* File: test/mlcr_top_props.sv */
// Checker for the lookup and config group, bound to its top.
// Assumes one clock and the active low reset of that clock.
`timescale 1ns/1ns
`default_nettype none
module mlcr_top_props
	import mlcr_pkg::*;
(
	input wire logic mclk,
	input wire logic rstn,
	input wire mlcr_acc_t acc,
	input wire logic [7:0] rdata,
	input wire logic [15:0] fourth_monitor_input,
	input wire logic conv_done,
	input wire logic video_dac_auto_enable,
	input wire logic double_table_mode,
	input wire logic upper_half_select,
	input wire logic [7:0] table_addr,
	input wire logic [7:0] table_data,
	input wire logic [7:0] video_gain_dac_value,
	input wire logic loop_sample,
	input wire logic [7:0] slave_address
);
	// ==========
	// Properties
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);
	logic [7:0] vidx; // Index worked out from the monitor result
	logic hwr; // Host write that may load the DAC value
	assign vidx = 8'(fourth_monitor_input >> 11) + 8'h80;
	assign hwr = acc.wr && acc.pw2_ok && acc.addr == 8'h85;
	AST_SINGLE: assert property (!double_table_mode |->
		table_addr == {3'b100, vidx[4:0]}) else $error("single addr");
	AST_DOUBLE: assert property (double_table_mode |->
		table_addr == {3'b100, upper_half_select, vidx[4:1]})
		else $error("double addr");
	AST_LOAD: assert property (conv_done |=>
		video_gain_dac_value == $past(table_data)) else $error("dac load");
	// Only a conversion or an allowed write may move the DAC value
	AST_LOCK: assert property (!conv_done &&
		!(hwr && !video_dac_auto_enable) |=>
		$stable(video_gain_dac_value)) else $error("dac lock");
	AST_NOPW: assert property (!acc.pw2_ok |->
		rdata == 8'h00) else $error("no password read");
	AST_RATE: assert property (acc.addr == 8'h88 |->
		rdata[7:4] == 4'h0) else $error("rate upper");
	AST_GAP: assert property (loop_sample |=>
		!loop_sample [*8]) else $error("sample gap");
	AST_ADDR: assert property ($changed(slave_address) |->
		$past(acc.wr && acc.pw2_ok, 2)) else $error("slave address");
endmodule
bind mlcr_top mlcr_top_props props_u (.mclk, .rstn, .acc, .rdata,
	.fourth_monitor_input, .conv_done, .video_dac_auto_enable,
	.double_table_mode, .upper_half_select, .table_addr, .table_data,
	.video_gain_dac_value, .loop_sample, .slave_address);
`default_nettype wire

/* File: test/test_mlcr_top.sv */
// Bench for the lookup and config group, with a host model.
// Assumes the table memory answers addr xor 5ah in the same cycle.
`timescale 1ns/1ns
`default_nettype none
module test_mlcr_top;
	import mlcr_pkg::*;
	// ==========
	// Signals
	localparam logic [7:0] ID = 8'h2e; // Arbitrary value
	localparam logic [7:0] REV = 8'h07; // Arbitrary value
	logic mclk = 1'b0, rstn = 1'b0, conv_done = 1'b0;
	logic video_dac_auto_enable = 1'b0, double_table_mode = 1'b0;
	logic upper_half_select = 1'b0, burst_enable_input = 1'b0;
	logic transmit_disable_input = 1'b0, startup_active = 1'b0;
	logic bias_step_tick = 1'b0, fault_present = 1'b0;
	// Supply starts good, latch suppression off; t_supply changes both
	logic supply_low_alarm_enabled = 1'b0, supply_above_low = 1'b1;
	logic [15:0] fourth_monitor_input = 16'h0000;
	logic [7:0] alarm_state = 8'h00, alarm_fault_enable = 8'h00;
	logic [12:0] bias_target = 13'h0000, laser_bias_output;
	logic [7:0] rdata, table_addr, table_data, video_gain_dac_value;
	logic [7:0] slave_address;
	logic loop_sample, shutdown_gate_output, transmit_fault_output;
	mlcr_acc_t acc;
	int err_total = 0;
	int n_checks = 0;
	assign table_data = table_addr ^ 8'h5a;
	initial forever #5 mclk = ~mclk;
	mlcr_top #(.PART_ID(ID), .PART_REV(REV)) dut_u (.mclk, .rstn, .acc,
		.rdata, .fourth_monitor_input, .conv_done, .video_dac_auto_enable,
		.double_table_mode, .upper_half_select, .table_addr, .table_data,
		.video_gain_dac_value, .burst_enable_input, .loop_sample,
		.alarm_state, .alarm_fault_enable, .supply_low_alarm_enabled,
		.supply_above_low, .transmit_disable_input, .fault_present,
		.shutdown_gate_output, .transmit_fault_output, .slave_address,
		.startup_active, .bias_step_tick, .bias_target, .laser_bias_output);
	mlcr_host host_u (.mclk, .rdata, .acc);
	// ==========
	// Helpers
	task automatic chk(input string nm, input logic [15:0] s,
		input logic [15:0] e);
		n_checks++;
		if (s !== e)
		begin
			err_total++;
			$display("MISMATCH %s exp %h seen %h", nm, e, s);
		end
	endtask
	task automatic rc(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		host_u.rd(a, d);
		chk($sformatf("reg %h", a), d, e);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask
	// Waits for a sample pulse, bounded
	task automatic wls(output int n);
		n = 1;
		@(posedge mclk);
		while (loop_sample !== 1'b1 && n < 2000)
		begin
			@(posedge mclk);
			n++;
		end
	endtask
	// ==========
	// Scenarios
	task automatic t_regs();
		rc(8'h85, 8'h00);
		rc(8'h8a, 8'h00);
		host_u.wr(8'h86, 8'hff);
		rc(8'h86, ID);
		rc(8'h87, REV);
		host_u.wr(8'h88, 8'hff);
		rc(8'h88, 8'h0f);
		rc(8'hff, 8'h00);
		host_u.pw = 1'b0;
		rc(8'h86, 8'h00);
		host_u.pw = 1'b1;
	endtask
	// Single, double lower, double upper
	task automatic t_lut();
		logic [15:0] m;
		logic [7:0] v;
		logic [7:0] ea;
		for (int i = 0; i < 3; i++)
		begin
			m = 16'hf800 - 16'(i) * 16'h5000;
			v = 8'(m / 16'h0800) + 8'h80;
			ea = (i == 0) ? {3'b100, v[4:0]} : {3'b100, i == 2, v[4:1]};
			@(posedge mclk);
			double_table_mode <= (i > 0);
			upper_half_select <= (i == 2);
			fourth_monitor_input <= m;
			conv_done <= 1'b1;
			@(posedge mclk);
			conv_done <= 1'b0;
			chk("table_addr", table_addr, ea);
			rc(8'h85, ea ^ 8'h5a);
		end
	endtask
	task automatic t_dac();
		host_u.wr(8'h85, 8'h33);
		rc(8'h85, 8'h33);
		video_dac_auto_enable <= 1'b1;
		host_u.wr(8'h85, 8'hcc);
		rc(8'h85, 8'h33);
		video_dac_auto_enable <= 1'b0;
		host_u.pw = 1'b0;
		host_u.wr(8'h85, 8'hcc);
		host_u.pw = 1'b1;
		rc(8'h85, 8'h33);
	endtask
	task automatic t_gate();
		host_u.wr(8'h89, 8'hff);
		rc(8'h89, 8'hd0);
		chk("gate", shutdown_gate_output, 1'b1);
		host_u.wr(8'h89, 8'h00);
		cyc(2);
		chk("gate", shutdown_gate_output, 1'b0);
		alarm_state <= 8'h05;
		alarm_fault_enable <= 8'h04;
		cyc(3);
		chk("fault", transmit_fault_output, 1'b1);
		alarm_fault_enable <= 8'h0a;
		cyc(3);
		chk("fault", transmit_fault_output, 1'b0);
		host_u.wr(8'h89, 8'h40);
		alarm_state <= 8'h02;
		cyc(3);
		alarm_state <= 8'h00;
		cyc(3);
		chk("latched", transmit_fault_output, 1'b1);
		transmit_disable_input <= 1'b1;
		cyc(6);
		chk("cleared", transmit_fault_output, 1'b0);
	endtask
	task automatic t_addr();
		host_u.wr(8'h89, 8'h00);
		cyc(2);
		chk("slave", slave_address, 8'ha2);
		host_u.wr(8'h8c, 8'h5a);
		host_u.wr(8'h89, 8'h10);
		cyc(2);
		chk("slave", slave_address, 8'h5a);
	endtask
	// First is the least delay in cycles; pin sync, idle step and wait add up to five
	task automatic t_samp(input logic [3:0] code, input int first,
		input int rep);
		int n;
		host_u.wr(8'h88, {4'h0, code});
		burst_enable_input <= 1'b1;
		wls(n);
		chk("first", n >= first && n <= first + 5, 1'b1);
		wls(n);
		chk("period", 16'(n), 16'(rep));
		burst_enable_input <= 1'b0;
		cyc(5);
	endtask
	task automatic t_bias(input logic [7:0] s, input logic [12:0] e);
		host_u.wr(8'h8a, s);
		startup_active <= 1'b1;
		bias_target <= 13'h1fff;
		bias_step_tick <= 1'b1;
		@(posedge mclk);
		bias_step_tick <= 1'b0;
		cyc(2);
		chk("bias", laser_bias_output, e);
	endtask
	// Mid-run reset with the supply still low: latching must wait
	task automatic t_supply();
		supply_above_low <= 1'b0;
		supply_low_alarm_enabled <= 1'b1;
		rstn <= 1'b0;
		cyc(2);
		rstn <= 1'b1;
		host_u.wr(8'h89, 8'h40);
		alarm_fault_enable <= 8'h02;
		alarm_state <= 8'h02;
		cyc(3);
		alarm_state <= 8'h00;
		cyc(3);
		chk("held off", transmit_fault_output, 1'b0);
		supply_above_low <= 1'b1;
		alarm_state <= 8'h02;
		cyc(3);
		alarm_state <= 8'h00;
		cyc(3);
		chk("latched", transmit_fault_output, 1'b1);
	endtask
	// ==========
	// Run
	task automatic results();
		if (err_total == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial
	begin
		cyc(20);
		rstn <= 1'b1;
		t_regs();
		t_lut();
		t_dac();
		t_gate();
		t_addr();
		t_samp(4'h0, 350 / 10, 800 / 10);
		t_samp(4'hf, 3150 / 10, 6400 / 10);
		t_bias(8'h00, 13'h0001);
		t_bias(8'h01, 13'h0021);
		t_supply();
		results();
	end
	// Cuts a hang short well past the longest sample wait
	initial
	begin
		#200000;
		err_total++;
		results();
	end
endmodule
`default_nettype wire
